// file: drive_control_status_word.sv
// drive command word decoder and condition word composer
`include "drive_ctrl_defs.svh"

module drive_control_status_word #(
	parameter int unsigned READY_CYCLES = 32'(`READY_CYCLES)
) (
	// clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	// received first process word of a telegram
	input  wire logic [15:0]                 cmd_word,
	input  wire logic                        cmd_strobe,
	input  wire logic                        cmd_good,
	// configuration
	input  wire drive_ctrl_pkg::profile_t    profile,
	input  wire drive_ctrl_pkg::gate_mode_t  gate_coast,
	input  wire drive_ctrl_pkg::gate_mode_t  gate_quick,
	input  wire drive_ctrl_pkg::gate_mode_t  gate_start,
	input  wire drive_ctrl_pkg::gate_mode_t  gate_setup,
	input  wire logic                        stop_out_option,
	input  wire logic                        multi_setup_en,
	// digital input pins
	input  wire drive_ctrl_pkg::din_t        din_pins,
	// drive core condition
	input  wire drive_ctrl_pkg::drive_state_t drv_state,
	// outputs
	output drive_ctrl_pkg::drive_cmd_t       cmd_q,
	output logic                             trip_reset_q,
	output logic                             stop_output_q,
	output logic [15:0]                      status_q
);
	// ==========================================================
	// input synchroniser
	drive_ctrl_pkg::din_t din_meta_q;
	drive_ctrl_pkg::din_t din_q;
	always_ff @(posedge clk_sys) begin
		din_meta_q <= din_pins;
		din_q      <= din_meta_q;
	end

	function automatic logic gate_fn(input drive_ctrl_pkg::gate_mode_t m,
		input logic bus_b, input logic din_b);
		case (m)
			drive_ctrl_pkg::GATE_DIN: gate_fn = din_b;
			drive_ctrl_pkg::GATE_BUS: gate_fn = bus_b;
			drive_ctrl_pkg::GATE_AND: gate_fn = bus_b & din_b;
			default:                  gate_fn = bus_b | din_b;
		endcase
	endfunction

	// ==========================================================
	// applied command word
	logic [15:0] cw_q;
	wire         take_word = cmd_strobe & cmd_good & cmd_word[`CW_VALID];
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cw_q <= `CW_RESET_VAL;
		end else if (take_word) begin
			cw_q <= cmd_word;
		end
	end

	// ==========================================================
	// decode
	wire vendor   = (profile == drive_ctrl_pkg::PROF_VENDOR);
	// in the vendor profile bits 00 and 02 are no stop commands
	wire on1      = vendor | cw_q[`CW_RAMP];
	wire on2      = cw_q[`CW_COAST];
	wire on3      = vendor | cw_q[`CW_QUICK];
	wire en_coast = gate_fn(gate_coast, cw_q[`CW_COAST_EN], din_q.coast_en);
	wire en_quick = gate_fn(gate_quick, cw_q[`CW_QSTOP], din_q.quick_en);
	wire en_start = gate_fn(gate_start, cw_q[`CW_START], din_q.start);
	wire setup_b  = gate_fn(gate_setup, cw_q[`CW_SETUP], din_q.setup);
	wire rst_b    = cw_q[`CW_RESET] | din_q.trip_reset;
	wire jog1_b   = cw_q[`CW_JOG1] | din_q.jog;
	wire rev_b    = cw_q[`CW_REV] | din_q.reverse;
	// jog runs from a quick-stop state with the stop bits released
	wire jog_ok   = ~en_quick & on1 & on2 & on3 & en_coast;
	wire permit   = on1 & on2 & on3 & en_coast & en_quick & en_start;

	drive_ctrl_pkg::drive_cmd_t cmd_d;
	always_comb begin
		cmd_d                = '0;
		cmd_d.ramp_stop_cmd  = ~on1 | ~en_start;
		cmd_d.coast_stop_cmd = ~on2 | ~en_coast;
		cmd_d.quick_stop_cmd = ~on3 | ~en_quick;
		cmd_d.freeze         = ~cw_q[`CW_FREEZE];
		cmd_d.run_permit     = permit;
		cmd_d.jog1           = jog_ok & jog1_b;
		cmd_d.jog2           = jog_ok & ~jog1_b & ~vendor & cw_q[`CW_JOG2];
		cmd_d.ref_down       = ~vendor & cw_q[`CW_DOWN];
		cmd_d.ref_up         = ~vendor & ~cw_q[`CW_DOWN] & cw_q[`CW_UP];
		cmd_d.setup_sel      = multi_setup_en & setup_b;
		cmd_d.reverse        = rev_b;
		cmd_d.preset_sel     = vendor & cw_q[`CW_RAMP];
		cmd_d.dc_brake       = vendor & ~cw_q[`CW_QUICK];
		cmd_d.out_activate   = vendor & cw_q[`CW_DOWN] & stop_out_option;
	end

	// ==========================================================
	// trip reset and ready timer
	logic       rst_b_q;
	wire        reset_pulse = rst_b & ~rst_b_q;
	drive_ctrl_pkg::ready_state_t rdy_q;
	logic [31:0] rdy_cnt_q;
	wire        rdy_last = (rdy_cnt_q == READY_CYCLES - 32'd1);
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rst_b_q      <= 1'b0;
			trip_reset_q <= 1'b0;
			rdy_q        <= drive_ctrl_pkg::RDY_WAIT;
			rdy_cnt_q    <= 32'd0;
		end else begin
			rst_b_q      <= rst_b;
			trip_reset_q <= reset_pulse;
			if (reset_pulse) begin
				rdy_q     <= drive_ctrl_pkg::RDY_WAIT;
				rdy_cnt_q <= 32'd0;
			end else begin
				case (rdy_q)
					drive_ctrl_pkg::RDY_WAIT: begin
						rdy_cnt_q <= rdy_cnt_q + 32'd1;
						if (rdy_last) begin
							rdy_q <= drive_ctrl_pkg::RDY_OK;
						end
					end
					drive_ctrl_pkg::RDY_OK: rdy_cnt_q <= 32'd0;
					default: rdy_q <= drive_ctrl_pkg::RDY_WAIT;
				endcase
			end
		end
	end

	// ==========================================================
	// start disable latch: a set in the clearing cycle wins
	logic start_dis_q;
	logic on2_q;
	logic on3_q;
	wire  sd_set = reset_pulse | (on2_q & ~on2) | (on3_q & ~on3);
	wire  sd_clr = ~cw_q[`CW_RAMP] & cw_q[`CW_COAST] & cw_q[`CW_QUICK] & cw_q[`CW_VALID];
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			start_dis_q <= 1'b1;
			on2_q       <= 1'b0;
			on3_q       <= 1'b0;
		end else begin
			on2_q <= on2;
			on3_q <= on3;
			if (sd_set) begin
				start_dis_q <= 1'b1;
			end else if (sd_clr) begin
				start_dis_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// condition word and command outputs
	wire trip = drv_state.trip;
	wire stop_cmd = ~cw_q[`CW_RAMP] | ~cw_q[`CW_COAST] | ~cw_q[`CW_QUICK] | ~en_start;
	logic [15:0] status_d;
	always_comb begin
		status_d                = 16'h0000;
		status_d[`SW_CTRL_RDY]  = on1 & on2 & on3 & ~trip;
		status_d[`SW_DRV_RDY]   = status_d[`SW_CTRL_RDY] & (rdy_q == drive_ctrl_pkg::RDY_OK);
		status_d[`SW_ENABLE]    = on1 & on2 & on3 & en_coast & ~trip;
		status_d[`SW_TRIP]      = trip;
		status_d[`SW_COAST_ON]  = ~cw_q[`CW_COAST];
		status_d[`SW_QUICK_ON]  = ~cw_q[`CW_QUICK];
		status_d[`SW_START_DIS] = ~vendor & start_dis_q;
		status_d[`SW_WARN]      = drv_state.warning;
		status_d[`SW_AT_REF]    = drv_state.at_ref;
		status_d[`SW_RUNNING]   = permit | ~drv_state.freq_zero;
		status_d[`SW_VOLT]      = drv_state.dc_fault;
		status_d[`SW_TORQUE]    = drv_state.torque_over;
		status_d[`SW_TIMER]     = drv_state.timer_over;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cmd_q         <= '0;
			stop_output_q <= 1'b0;
			status_q      <= `SW_RESET_VAL;
		end else begin
			cmd_q         <= cmd_d;
			// output is only raised once the shaft has stopped
			stop_output_q <= ~vendor & stop_cmd & drv_state.freq_zero & stop_out_option;
			status_q      <= status_d;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_bad_word;
		cmd_strobe && !(cmd_good && cmd_word[`CW_VALID]);
	endsequence
	sequence s_reset_edge;
		reset_pulse ##1 trip_reset_q;
	endsequence
	sequence s_jog_one;
		jog_ok && jog1_b;
	endsequence
	sequence s_catch_up;
		!vendor && cw_q[`CW_UP] && !cw_q[`CW_DOWN];
	endsequence
	sequence s_stop_out;
		!vendor && stop_cmd && drv_state.freq_zero && stop_out_option;
	endsequence
	sequence s_sd_clear;
		!vendor && sd_clr && !sd_set ##1 !vendor;
	endsequence

	AST_IGNORE_WORD: assert property (s_bad_word |=> $stable(cw_q))
		else $error("command word taken although invalid or bad");
	AST_TAKE_WORD: assert property (take_word |=> cw_q == $past(cmd_word))
		else $error("valid command word not applied");
	// jog runs out of a quick-stop state, so the quick stop stays asserted
	AST_JOG_PRIO: assert property (cmd_q.jog2
		|-> !cmd_q.jog1 && cmd_q.quick_stop_cmd && !cmd_q.coast_stop_cmd)
		else $error("jog two active against priority or gating");
	AST_REF_PRIO: assert property (!vendor && cw_q[`CW_DOWN]
		|=> cmd_q.ref_down && !cmd_q.ref_up)
		else $error("slow down did not win over catch up");
	AST_CTRL_RDY: assert property (!vendor && !cw_q[`CW_COAST]
		|=> !status_q[`SW_CTRL_RDY] && status_q[`SW_COAST_ON])
		else $error("control ready with coasting stop");
	AST_TRIP_RDY: assert property (trip |=> !status_q[`SW_CTRL_RDY] && status_q[`SW_TRIP])
		else $error("trip not reported");
	AST_RESET_WAIT: assert property (s_reset_edge |=> !status_q[`SW_DRV_RDY] [*2])
		else $error("drive ready right after trip reset");
	AST_READY_TIME: assert property ($rose(rdy_q == drive_ctrl_pkg::RDY_OK)
		|-> $past(rdy_cnt_q) == READY_CYCLES - 32'd1)
		else $error("ready reached at wrong count");
	AST_START_DIS: assert property (!vendor && sd_set ##1 !vendor
		|=> status_q[`SW_START_DIS])
		else $error("start disable not set");
	AST_VENDOR_SD: assert property (vendor |=> !status_q[`SW_START_DIS])
		else $error("start disable shown in vendor profile");
	AST_STOP_OUT: assert property (stop_output_q |-> $past(drv_state.freq_zero && stop_out_option))
		else $error("stop output without zero frequency or option");
	AST_SETUP: assert property (!multi_setup_en |=> !cmd_q.setup_sel)
		else $error("setup selected without multi setup");
	AST_RAMP_STOP: assert property (!on1 |=> cmd_q.ramp_stop_cmd)
		else $error("ramp stop not commanded");
	AST_COAST_STOP: assert property (!on2 |=> cmd_q.coast_stop_cmd && !cmd_q.run_permit)
		else $error("coasting stop not commanded");
	AST_QUICK_STOP: assert property (!on3 |=> cmd_q.quick_stop_cmd)
		else $error("quick stop not commanded");
	AST_STOP_OUT_SET: assert property (s_stop_out |=> stop_output_q)
		else $error("stop output missing at zero frequency");
	AST_COAST_GATE: assert property (!en_coast |=> cmd_q.coast_stop_cmd)
		else $error("gated coasting not commanded");
	AST_QUICK_GATE: assert property (!en_quick |=> cmd_q.quick_stop_cmd)
		else $error("gated quick stop not commanded");
	AST_FREEZE: assert property (!cw_q[`CW_FREEZE] |=> cmd_q.freeze)
		else $error("output frequency not frozen");
	AST_START_GATE: assert property (!en_start |=> cmd_q.ramp_stop_cmd && !cmd_q.run_permit)
		else $error("ramp stop from start bit missing");
	AST_TRIP_PULSE: assert property (trip_reset_q |=> !trip_reset_q)
		else $error("trip reset longer than one cycle");
	AST_JOG_ONE: assert property (s_jog_one |=> cmd_q.jog1 && !cmd_q.jog2)
		else $error("jog one not selected");
	AST_JOG_BLOCK: assert property (!jog_ok |=> !cmd_q.jog1 && !cmd_q.jog2)
		else $error("jog outside its stop state");
	AST_REF_UP: assert property (s_catch_up |=> cmd_q.ref_up && !cmd_q.ref_down)
		else $error("catch up not commanded");
	AST_SETUP_SEL: assert property (multi_setup_en && setup_b |=> cmd_q.setup_sel)
		else $error("second setup not selected");
	AST_REVERSE: assert property (rev_b |=> cmd_q.reverse)
		else $error("reversing not commanded");
	AST_DIN_RESET: assert property (din_q.trip_reset && !rst_b_q |=> trip_reset_q)
		else $error("trip reset input not combined");
	AST_CTRL_READY: assert property (on1 && on2 && on3 && !trip |=> status_q[`SW_CTRL_RDY])
		else $error("control ready not shown");
	AST_WARN: assert property (drv_state.warning |=> status_q[`SW_WARN])
		else $error("warning not reported");
	AST_COAST_FLAG: assert property (cw_q[`CW_COAST] |=> !status_q[`SW_COAST_ON])
		else $error("coasting flag set with bit released");
	AST_QUICK_FLAG: assert property (!cw_q[`CW_QUICK] |=> status_q[`SW_QUICK_ON])
		else $error("quick stop flag not shown");
	AST_SD_CLEAR: assert property (s_sd_clear |=> !status_q[`SW_START_DIS])
		else $error("start disable not cleared");
	AST_AT_REF: assert property (drv_state.at_ref |=> status_q[`SW_AT_REF])
		else $error("at reference not reported");
	AST_RUNNING: assert property (!drv_state.freq_zero |=> status_q[`SW_RUNNING])
		else $error("running not reported");
	AST_DC_FAULT: assert property (drv_state.dc_fault |=> status_q[`SW_VOLT])
		else $error("dc voltage fault not reported");
	AST_TORQUE: assert property (drv_state.torque_over |=> status_q[`SW_TORQUE])
		else $error("torque limit not reported");
	AST_PRESET: assert property (vendor && cw_q[`CW_RAMP] |=> cmd_q.preset_sel)
		else $error("preset two not selected");

endmodule // drive_control_status_word

// file: drive_ctrl_defs.svh
// constants for the drive command and condition words
`ifndef DRIVE_CTRL_DEFS_SVH
`define DRIVE_CTRL_DEFS_SVH
// ==========================================================
// command word bit positions
`define CW_RAMP      0
`define CW_COAST     1
`define CW_QUICK     2
`define CW_COAST_EN  3
`define CW_QSTOP     4
`define CW_FREEZE    5
`define CW_START     6
`define CW_RESET     7
`define CW_JOG1      8
`define CW_JOG2      9
`define CW_VALID     10
`define CW_DOWN      11
`define CW_UP        12
`define CW_SETUP     13
`define CW_REV       15
// ==========================================================
// condition word bit positions
`define SW_CTRL_RDY  0
`define SW_DRV_RDY   1
`define SW_ENABLE    2
`define SW_TRIP      3
`define SW_COAST_ON  4
`define SW_QUICK_ON  5
`define SW_START_DIS 6
`define SW_WARN      7
`define SW_AT_REF    8
`define SW_RUNNING   11
`define SW_VOLT      13
`define SW_TORQUE    14
`define SW_TIMER     15
// ==========================================================
// reset values and timing
`define CW_RESET_VAL 16'h0000
`define SW_RESET_VAL 16'h0040
`define CLK_HZ       64'd40000000
`define READY_MS     64'd1500
`define READY_CYCLES ((`READY_MS * `CLK_HZ) / 64'd1000)
`endif

// file: drive_ctrl_pkg.sv
// types shared by the drive command interpreter
package drive_ctrl_pkg;
	typedef enum logic [1:0] {
		GATE_DIN = 2'b00,
		GATE_BUS = 2'b01,
		GATE_AND = 2'b10,
		GATE_OR  = 2'b11
	} gate_mode_t;
	typedef enum logic {
		PROF_STD    = 1'b0,
		PROF_VENDOR = 1'b1
	} profile_t;
	typedef enum logic {
		RDY_WAIT = 1'b0,
		RDY_OK   = 1'b1
	} ready_state_t;
	// digital input functions, one bit each
	typedef struct packed {
		logic coast_en;
		logic quick_en;
		logic start;
		logic setup;
		logic reverse;
		logic trip_reset;
		logic jog;
	} din_t;
	// condition of the power stage reported by the drive core
	typedef struct packed {
		logic trip;
		logic warning;
		logic freq_zero;
		logic at_ref;
		logic dc_fault;
		logic torque_over;
		logic timer_over;
	} drive_state_t;
	// decoded commands towards the drive core
	typedef struct packed {
		logic ramp_stop_cmd;
		logic coast_stop_cmd;
		logic quick_stop_cmd;
		logic freeze;
		logic run_permit;
		logic jog1;
		logic jog2;
		logic ref_down;
		logic ref_up;
		logic setup_sel;
		logic reverse;
		logic preset_sel;
		logic dc_brake;
		logic out_activate;
	} drive_cmd_t;
endpackage

// file: leader_model.sv
// bus leader model that hands over the first process word of each telegram
module leader_model (
	// clock
	input  wire logic   clk_sys,
	// first process word of the telegram towards the drive
	output logic [15:0] cmd_word,
	output logic        cmd_strobe,
	output logic        cmd_good
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cmd_word = 16'h0000;
		cmd_strobe = 1'b0;
		cmd_good = 1'b0;
	end
	// ==========================================================
	// one telegram, after gap idle cycles
	task automatic send(input logic [15:0] w, input logic g, input int gap);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		#2;
		cmd_word = w;
		cmd_good = g;
		cmd_strobe = 1'b1;
		@(posedge clk_sys);
		#2;
		cmd_strobe = 1'b0;
		// released lines show garbage so a stale word is never mistaken for valid
		cmd_word = ~w;
		cmd_good = ~g;
	endtask
endmodule // leader_model

// file: tb.sv
// self-checking bench for the drive command interpreter
module tb;
	timeunit 1ns;
	timeprecision 100ps;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: got %h exp %h", $time, a, b); end end
	localparam int unsigned RDY = 20;
	logic                         clk_sys = 1'b0;
	logic                         rst_n = 1'b0;
	logic [15:0]                  cmd_word;
	logic                         cmd_strobe;
	logic                         cmd_good;
	drive_ctrl_pkg::profile_t     profile = drive_ctrl_pkg::PROF_STD;
	logic                         stop_out_option = 1'b0;
	logic                         multi_setup_en = 1'b1;
	drive_ctrl_pkg::drive_state_t drv = '0;
	drive_ctrl_pkg::gate_mode_t   gate_coast = drive_ctrl_pkg::GATE_BUS;
	drive_ctrl_pkg::din_t         din = '0;
	drive_ctrl_pkg::drive_cmd_t   cmd_q;
	drive_ctrl_pkg::drive_cmd_t   snap;
	logic                         trip_reset_q;
	logic                         stop_output_q;
	logic [15:0]                  status_q;
	logic [15:0]                  w;
	logic                         jog_ok;
	int                           fails = 0;
	int                           num_checks = 0;
	int                           n;
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	leader_model leader (.clk_sys(clk_sys), .cmd_word(cmd_word), .cmd_strobe(cmd_strobe),
		.cmd_good(cmd_good));
	drive_control_status_word #(.READY_CYCLES(RDY)) uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .cmd_word(cmd_word), .cmd_strobe(cmd_strobe),
		.cmd_good(cmd_good), .profile(profile), .gate_coast(gate_coast),
		.gate_quick(drive_ctrl_pkg::GATE_BUS), .gate_start(drive_ctrl_pkg::GATE_BUS),
		.gate_setup(drive_ctrl_pkg::GATE_BUS), .stop_out_option(stop_out_option),
		.multi_setup_en(multi_setup_en), .din_pins(din),
		.drv_state(drv), .cmd_q(cmd_q), .trip_reset_q(trip_reset_q),
		.stop_output_q(stop_output_q), .status_q(status_q));
	// ==========================================================
	// expected condition word, only the bits that follow directly from inputs
	function automatic logic [15:0] exp_status(input logic [15:0] c,
		input drive_ctrl_pkg::drive_state_t s);
		logic [15:0] r;
		r = 16'h0000;
		r[0] = c[0] & c[1] & c[2] & ~s.trip;
		r[2] = (&c[3:0]) & ~s.trip;
		r[3] = s.trip;
		r[4] = ~c[1];
		r[5] = ~c[2];
		r[7] = s.warning;
		r[8] = s.at_ref;
		r[11] = ((&c[4:0]) & c[6]) | ~s.freq_zero;
		r[13] = s.dc_fault;
		r[14] = s.torque_over;
		r[15] = s.timer_over;
		return r;
	endfunction
	// word goes out, then wait until the decoded outputs have landed
	task automatic apply(input logic [15:0] cw, input logic g);
		w = cw;
		leader.send(cw, g, 32'($urandom_range(2)));
		@(posedge clk_sys);
		#2;
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(65));
		repeat (8) @(posedge clk_sys);
		#2;
		`CHK(status_q, 16'h0040)
		`CHK(trip_reset_q, 1'b0)
		rst_n = 1'b1;
		$display("test reset done");
		// first three words are the jog and speed-adjust corners
		for (int i = 0; i < 24; i++) begin
			drv = drive_ctrl_pkg::drive_state_t'(7'($urandom));
			multi_setup_en = 1'($urandom);
			w = (i == 0) ? 16'h070F : (i == 1) ? 16'h1C07 : (i == 2) ? 16'h060F :
				((16'($urandom) & 16'hBF7F) | 16'h0400);
			apply(w, 1'b1);
			jog_ok = ~w[4] & (&w[3:0]);
			`CHK(cmd_q.jog1, jog_ok & w[8])
			`CHK(cmd_q.jog2, jog_ok & ~w[8] & w[9])
			`CHK(cmd_q.ref_down, w[11])
			`CHK(cmd_q.ref_up, w[12] & ~w[11])
			`CHK(cmd_q.reverse, w[15])
			`CHK(cmd_q.freeze, ~w[5])
			`CHK(cmd_q.setup_sel, w[13] & multi_setup_en)
			`CHK(cmd_q.ramp_stop_cmd, ~w[0] | ~w[6])
			`CHK(cmd_q.coast_stop_cmd, ~w[1] | ~w[3])
			`CHK(cmd_q.quick_stop_cmd, ~w[2] | ~w[4])
			`CHK(cmd_q.run_permit, (&w[4:0]) & w[6])
			`CHK(status_q & 16'hE9BD, exp_status(w, drv))
		end
		$display("test random words done");
		// a bad telegram and an invalid word must both leave the decoded commands as they were
		snap = cmd_q;
		apply(~w | 16'h0400, 1'b0);
		`CHK(cmd_q, snap)
		apply(~w & 16'hFBFF, 1'b1);
		`CHK(cmd_q, snap)
		$display("test refused words done");
		drv = '0;
		apply(16'h0407, 1'b1);
		apply(16'h0487, 1'b1);
		`CHK(trip_reset_q, 1'b1)
		@(posedge clk_sys);
		#2;
		`CHK(trip_reset_q, 1'b0)
		`CHK(status_q[6], 1'b1)
		`CHK(status_q[1], 1'b0)
		n = 0;
		while (status_q[1] !== 1'b1 && n < 100) begin
			@(posedge clk_sys);
			#2;
			n++;
		end
		if (n == 100) begin
			fails++;
			test_done();
		end
		`CHK(n > RDY - 4, 1'b1)
		$display("test trip reset done");
		// the start disable latch answers one cycle after the word lands
		apply(16'h0406, 1'b1);
		@(posedge clk_sys);
		#2;
		`CHK(status_q[6], 1'b0)
		apply(16'h0405, 1'b1);
		@(posedge clk_sys);
		#2;
		`CHK(status_q[6], 1'b1)
		$display("test start disable done");
		drv.freq_zero = 1'b1;
		stop_out_option = 1'b1;
		apply(16'h0406, 1'b1);
		`CHK(stop_output_q, 1'b1)
		stop_out_option = 1'b0;
		repeat (2) @(posedge clk_sys);
		#2;
		`CHK(stop_output_q, 1'b0)
		$display("test stop output done");
		// pins pass two synchroniser stages before the decoder sees them
		din.reverse = 1'b1;
		din.trip_reset = 1'b1;
		gate_coast = drive_ctrl_pkg::GATE_AND;
		repeat (3) @(posedge clk_sys);
		#2;
		`CHK(trip_reset_q, 1'b1)
		apply(16'h040E, 1'b1);
		`CHK(cmd_q.reverse, 1'b1)
		`CHK(cmd_q.coast_stop_cmd, 1'b1)
		gate_coast = drive_ctrl_pkg::GATE_OR;
		@(posedge clk_sys);
		#2;
		`CHK(cmd_q.coast_stop_cmd, 1'b0)
		$display("test input gating done");
		profile = drive_ctrl_pkg::PROF_VENDOR;
		apply(16'h0405, 1'b1);
		`CHK(cmd_q.preset_sel, 1'b1)
		`CHK(status_q[6], 1'b0)
		apply(16'h0404, 1'b1);
		`CHK(cmd_q.preset_sel, 1'b0)
		$display("test vendor profile done");
		test_done();
	end
endmodule // tb
